// ===== shared/irq_rcc_pkg.sv
// Package for the reset-cause and interrupt-source block.
// Holds register indices, bit positions, reset values and shared carriers.
package irq_rcc_pkg;
    localparam int ADDR_W = 3;
    // Register indices on the plain register port
    localparam logic [ADDR_W-1:0] ADDR_RESET_CAUSE = 3'h0;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_CTRL_A = 3'h1;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_CTRL_B = 3'h2;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_CTRL_C = 3'h3;
    localparam logic [ADDR_W-1:0] ADDR_PORT_A_MASK = 3'h4;
    localparam logic [ADDR_W-1:0] ADDR_PORT_B_MASK = 3'h5;
    // reset_cause_control bits
    localparam int RC_PRIO_EN = 7;
    localparam int RC_SW_BOR = 6;
    localparam int RC_RESET_OP = 4;
    localparam int RC_WDT = 3;
    localparam int RC_SLEEP = 2;
    localparam int RC_POR = 1;
    localparam int RC_BOR = 0;
    // irq_control_a bits
    localparam int CA_GLB_HIGH = 7;
    localparam int CA_GLB_LOW = 6;
    localparam int CA_TMR_EN = 5;
    localparam int CA_EXT0_EN = 4;
    localparam int CA_PCH_EN = 3;
    localparam int CA_TMR_FLAG = 2;
    localparam int CA_EXT0_FLAG = 1;
    localparam int CA_PCH_FLAG = 0;
    // irq_control_b bits
    localparam int CB_EDGE0 = 6;
    localparam int CB_EDGE1 = 5;
    localparam int CB_EDGE2 = 4;
    localparam int CB_TMR_PRIO = 2;
    localparam int CB_PCH_PRIO = 0;
    // irq_control_c bits
    localparam int CC_EXT2_PRIO = 7;
    localparam int CC_EXT1_PRIO = 6;
    localparam int CC_EXT2_EN = 4;
    localparam int CC_EXT1_EN = 3;
    localparam int CC_EXT2_FLAG = 1;
    localparam int CC_EXT1_FLAG = 0;
    // Reset values and constants
    localparam logic [1:0] BOR_CFG_SW = 2'h1;
    localparam logic [7:0] TMR_MAX8 = 8'hff;
    localparam logic [15:0] TMR_MAX16 = 16'hffff;
    localparam logic [7:0] CTRL_B_RST = 8'h75;
    localparam logic [7:0] CTRL_C_RST = 8'hc0;
    localparam logic [7:0] ZERO8 = 8'h00;

    typedef struct packed {
        logic [20:0] pc;
        logic [7:0] working;
        logic [7:0] status;
        logic [7:0] bank;
    } context_s;

    typedef struct packed {
        logic por_reset_op;
        logic wdt_expiry;
        logic brownout;
        logic reset_op;
        logic clear_op;
        logic sleep_op;
    } core_event_s;
endpackage : irq_rcc_pkg

// ===== core/irq_sources_reset_cause.sv
// Reset-cause register, external edge, timer-0 and pin-change interrupt sources,
// priority steering and interrupt-entry context shadow.
// Assumes core events are one-cycle pulses on i_core_clk; pins are asynchronous.
// i_resetn is the power-on reset.
// Behaviour
// - Priority-enable bit selects two levels or one
// - Software brown-out bit active only when config 01
// - Software brown-out bit resets to one when active
// - Reset opcode clears flag; POR or write sets
// - Watchdog flag: set power-up/clear/sleep, cleared expiry
// - Sleep flag: set power-up/clear op, cleared sleep
// - Power-on status zero after POR until written
// - Brown-out status zero after brown-out until written
// - Edge-select bit picks rising or falling edge
// - Selected edge sets flag; enable gates request
// - Enabled external source wakes core from sleep
// - External 1,2 own priority; 0 always high
// - Timer overflow FFh or FFFFh sets flag
// - Timer interrupt has own enable and priority
// - Masked pin change sets shared change flag
// - Entry pushes return PC, shadows working/status/bank
// - Priority bits act only with priority enabled
`timescale 1ns/1ps
module irq_sources_reset_cause
    import irq_rcc_pkg::*;
(
    input wire logic i_core_clk, // 25 MHz core clock
    input wire logic i_resetn, // Power-on reset, async, active low
    input wire logic [ADDR_W-1:0] i_addr, // Register index
    input wire logic [7:0] i_wdata, // Write data
    input wire logic i_wr, // Write strobe
    input wire logic i_rd, // Read strobe
    output logic [7:0] o_rdata, // Read data, cycle after strobe
    input wire logic [1:0] i_bor_config, // Brown-out configuration field
    input wire core_event_s i_event, // Core reset and opcode pulses
    input wire logic [2:0] i_ext_irq_pin, // External interrupt pins
    input wire logic [7:0] i_port_a_pin, // Port A pins
    input wire logic [7:0] i_port_b_pin, // Port B pins
    input wire logic i_tmr_tick, // Timer-0 increment pulse
    input wire logic i_tmr_wide, // Timer-0 16-bit mode
    input wire logic [15:0] i_tmr_value, // Timer-0 count before tick
    input wire logic i_irq_entry, // Core enters interrupt
    input wire context_s i_context, // Return PC and core registers
    output logic o_bor_enable, // Brown-out reset enabled
    output logic o_irq_high, // High-priority request
    output logic o_irq_low, // Low-priority request
    output logic o_wake, // Wake from idle or sleep
    output logic o_stack_push, // Push return PC pulse
    output logic [20:0] o_push_pc, // PC to push
    output context_s o_shadow // Fast return shadow
);
    // reset_cause_control
    logic prio_en_reg, sw_bor_reg, reset_op_flag_reg, wdt_flag_reg, sleep_flag_reg;
    logic por_status_reg, bor_status_reg;
    // Sources and controls
    logic [7:0] ctrl_b_reg, ctrl_c_reg, port_a_mask_reg, port_b_mask_reg;
    logic glb_high_reg, glb_low_reg, tmr_en_reg, pch_en_reg;
    logic [2:0] ext_en_reg, ext_flag_reg;
    logic tmr_flag_reg, pch_flag_reg;
    // Synchronisers
    logic [2:0] ext_s1_reg, ext_s2_reg, ext_prev_reg;
    logic [15:0] port_s1_reg, port_s2_reg, port_prev_reg;
    logic [2:0] edge_sel, ext_prio, ext_edge;
    logic tmr_ovf, pch_event, sw_bor_active;
    logic wr_rc, wr_ca, wr_cc;
    logic [4:0] pend, prio;

    function automatic logic [7:0] rd_mux(input logic [ADDR_W-1:0] a);
        logic [7:0] r;
        r = ZERO8;
        unique case (a)
            ADDR_RESET_CAUSE: begin
                r[RC_PRIO_EN] = prio_en_reg;
                r[RC_SW_BOR] = sw_bor_active;
                r[RC_RESET_OP] = reset_op_flag_reg;
                r[RC_WDT] = wdt_flag_reg;
                r[RC_SLEEP] = sleep_flag_reg;
                r[RC_POR] = por_status_reg;
                r[RC_BOR] = bor_status_reg;
            end
            ADDR_IRQ_CTRL_A: begin
                r[CA_GLB_HIGH] = glb_high_reg;
                r[CA_GLB_LOW] = glb_low_reg;
                r[CA_TMR_EN] = tmr_en_reg;
                r[CA_EXT0_EN] = ext_en_reg[0];
                r[CA_PCH_EN] = pch_en_reg;
                r[CA_TMR_FLAG] = tmr_flag_reg;
                r[CA_EXT0_FLAG] = ext_flag_reg[0];
                r[CA_PCH_FLAG] = pch_flag_reg;
            end
            ADDR_IRQ_CTRL_B: r = ctrl_b_reg;
            ADDR_IRQ_CTRL_C: begin
                r = ctrl_c_reg;
                r[CC_EXT2_EN] = ext_en_reg[2];
                r[CC_EXT1_EN] = ext_en_reg[1];
                r[CC_EXT2_FLAG] = ext_flag_reg[2];
                r[CC_EXT1_FLAG] = ext_flag_reg[1];
            end
            ADDR_PORT_A_MASK: r = port_a_mask_reg;
            ADDR_PORT_B_MASK: r = port_b_mask_reg;
            default: r = ZERO8;
        endcase
        return r;
    endfunction : rd_mux

    assign wr_rc = i_wr && (i_addr == ADDR_RESET_CAUSE);
    assign wr_ca = i_wr && (i_addr == ADDR_IRQ_CTRL_A);
    assign wr_cc = i_wr && (i_addr == ADDR_IRQ_CTRL_C);
    assign sw_bor_active = sw_bor_reg && (i_bor_config == BOR_CFG_SW);
    assign o_bor_enable = (i_bor_config == BOR_CFG_SW) ? sw_bor_reg : i_bor_config[1];

    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) o_rdata <= ZERO8;
        else if (i_rd) o_rdata <= rd_mux(i_addr);
    end

    // Reset-cause flags: hardware events win over software writes
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            prio_en_reg <= 1'b0;
            sw_bor_reg <= 1'b1;
            reset_op_flag_reg <= 1'b1;
            wdt_flag_reg <= 1'b1;
            sleep_flag_reg <= 1'b1;
            por_status_reg <= 1'b0;
            bor_status_reg <= 1'b0;
        end else begin
            if (wr_rc) begin
                prio_en_reg <= i_wdata[RC_PRIO_EN];
                if (i_bor_config == BOR_CFG_SW) sw_bor_reg <= i_wdata[RC_SW_BOR];
                reset_op_flag_reg <= i_wdata[RC_RESET_OP];
                por_status_reg <= i_wdata[RC_POR];
                bor_status_reg <= i_wdata[RC_BOR];
            end
            if (i_event.reset_op) reset_op_flag_reg <= 1'b0;
            if (i_event.brownout) bor_status_reg <= 1'b0;
            if (i_event.clear_op) begin
                wdt_flag_reg <= 1'b1;
                sleep_flag_reg <= 1'b1;
            end else if (i_event.sleep_op) begin
                wdt_flag_reg <= 1'b1;
                sleep_flag_reg <= 1'b0;
            end
            if (i_event.wdt_expiry) wdt_flag_reg <= 1'b0;
        end
    end

    // Pin synchronisers and previous samples
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            ext_s1_reg <= '0;
            ext_s2_reg <= '0;
            ext_prev_reg <= '0;
            port_s1_reg <= '0;
            port_s2_reg <= '0;
            port_prev_reg <= '0;
        end else begin
            ext_s1_reg <= i_ext_irq_pin;
            ext_s2_reg <= ext_s1_reg;
            ext_prev_reg <= ext_s2_reg;
            port_s1_reg <= {i_port_b_pin, i_port_a_pin};
            port_s2_reg <= port_s1_reg;
            port_prev_reg <= port_s2_reg;
        end
    end

    assign edge_sel = {ctrl_b_reg[CB_EDGE2], ctrl_b_reg[CB_EDGE1], ctrl_b_reg[CB_EDGE0]};
    // Rising when select is one, falling when zero
    assign ext_edge = (edge_sel & ext_s2_reg & ~ext_prev_reg)
                    | (~edge_sel & ~ext_s2_reg & ext_prev_reg);
    assign tmr_ovf = i_tmr_tick && (i_tmr_wide ? (i_tmr_value == TMR_MAX16)
                                               : (i_tmr_value[7:0] == TMR_MAX8));
    assign pch_event = |((port_s2_reg ^ port_prev_reg) & {port_b_mask_reg, port_a_mask_reg});

    // Control registers
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            glb_high_reg <= 1'b0;
            glb_low_reg <= 1'b0;
            tmr_en_reg <= 1'b0;
            pch_en_reg <= 1'b0;
            ext_en_reg <= '0;
            ctrl_b_reg <= CTRL_B_RST;
            ctrl_c_reg <= CTRL_C_RST;
            port_a_mask_reg <= ZERO8;
            port_b_mask_reg <= ZERO8;
        end else if (i_wr) begin
            if (wr_ca) begin
                glb_high_reg <= i_wdata[CA_GLB_HIGH];
                glb_low_reg <= i_wdata[CA_GLB_LOW];
                tmr_en_reg <= i_wdata[CA_TMR_EN];
                pch_en_reg <= i_wdata[CA_PCH_EN];
                ext_en_reg[0] <= i_wdata[CA_EXT0_EN];
            end
            if (i_addr == ADDR_IRQ_CTRL_B) ctrl_b_reg <= i_wdata & CTRL_B_RST;
            if (wr_cc) begin
                ctrl_c_reg <= i_wdata & CTRL_C_RST;
                ext_en_reg[2:1] <= {i_wdata[CC_EXT2_EN], i_wdata[CC_EXT1_EN]};
            end
            if (i_addr == ADDR_PORT_A_MASK) port_a_mask_reg <= i_wdata;
            if (i_addr == ADDR_PORT_B_MASK) port_b_mask_reg <= i_wdata;
        end
    end

    // Source flags: a new event wins over a software clear
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            ext_flag_reg <= '0;
            tmr_flag_reg <= 1'b0;
            pch_flag_reg <= 1'b0;
        end else begin
            ext_flag_reg[0] <= (wr_ca ? i_wdata[CA_EXT0_FLAG] : ext_flag_reg[0]) | ext_edge[0];
            ext_flag_reg[1] <= (wr_cc ? i_wdata[CC_EXT1_FLAG] : ext_flag_reg[1]) | ext_edge[1];
            ext_flag_reg[2] <= (wr_cc ? i_wdata[CC_EXT2_FLAG] : ext_flag_reg[2]) | ext_edge[2];
            tmr_flag_reg <= (wr_ca ? i_wdata[CA_TMR_FLAG] : tmr_flag_reg) | tmr_ovf;
            pch_flag_reg <= (wr_ca ? i_wdata[CA_PCH_FLAG] : pch_flag_reg) | pch_event;
        end
    end

    // Pending per source: ext0, ext1, ext2, timer, pin change
    assign pend = {pch_flag_reg & pch_en_reg, tmr_flag_reg & tmr_en_reg,
                   ext_flag_reg & ext_en_reg};
    assign ext_prio = {ctrl_c_reg[CC_EXT2_PRIO], ctrl_c_reg[CC_EXT1_PRIO], 1'b1};
    // One level only when priorities are off
    assign prio = prio_en_reg ? {ctrl_b_reg[CB_PCH_PRIO], ctrl_b_reg[CB_TMR_PRIO], ext_prio}
                              : 5'h1f;
    assign o_irq_high = glb_high_reg && |(pend & prio);
    assign o_irq_low = prio_en_reg && glb_high_reg && glb_low_reg && |(pend & ~prio);
    assign o_wake = |pend;

    // Interrupt entry: push PC and fill the fast return shadow
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_stack_push <= 1'b0;
            o_push_pc <= '0;
            o_shadow <= '0;
        end else begin
            o_stack_push <= i_irq_entry;
            if (i_irq_entry) begin
                o_push_pc <= i_context.pc;
                o_shadow <= i_context;
            end
        end
    end

    a_edge_sets_flag: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        ext_edge[1] |=> ext_flag_reg[1]) else $error("edge did not set flag");
    a_rise_select: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        $rose(ext_s2_reg[0]) && edge_sel[0] |=> ext_flag_reg[0]) else $error("rise missed");
    a_fall_select: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        $fell(ext_s2_reg[2]) && !edge_sel[2] |=> ext_flag_reg[2]) else $error("fall missed");
    a_tmr_overflow: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        i_tmr_tick && !i_tmr_wide && i_tmr_value[7:0] == TMR_MAX8 |=> tmr_flag_reg)
        else $error("overflow missed");
    a_wide_overflow: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        i_tmr_tick && i_tmr_wide && i_tmr_value == TMR_MAX16 |=> tmr_flag_reg)
        else $error("wide overflow missed");
    a_change_flag: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        pch_event |=> pch_flag_reg) else $error("pin change missed");
    a_sleep_flags: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        i_event.sleep_op && !i_event.clear_op && !i_event.wdt_expiry |=> !sleep_flag_reg && wdt_flag_reg)
        else $error("sleep flags wrong");
    a_clear_flags: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        i_event.clear_op && !i_event.wdt_expiry |=> wdt_flag_reg && sleep_flag_reg)
        else $error("clear flags wrong");
    a_wdt_expiry: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        i_event.wdt_expiry |=> !wdt_flag_reg) else $error("watchdog flag not cleared");
    a_flags_readonly: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        wr_rc && i_event == '0 |=> $stable(wdt_flag_reg) && $stable(sleep_flag_reg))
        else $error("read-only flag written");
    a_reset_op_flag: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        i_event.reset_op |=> !reset_op_flag_reg) else $error("reset opcode flag set");
    a_bor_status: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        i_event.brownout |=> !bor_status_reg) else $error("brown-out status set");
    a_por_hold: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        !por_status_reg && !wr_rc |=> !por_status_reg) else $error("por status changed");
    a_sw_bor_gate: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        i_rd && i_addr == ADDR_RESET_CAUSE && i_bor_config != BOR_CFG_SW |=> !o_rdata[RC_SW_BOR])
        else $error("sw brown-out bit visible");
    a_sw_bor_write: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        wr_rc && i_bor_config != BOR_CFG_SW |=> $stable(sw_bor_reg)) else $error("sw brown-out written");
    a_ext0_high: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        glb_high_reg && pend[0] |-> o_irq_high) else $error("ext0 not high");
    a_prio_steer: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        prio_en_reg && glb_high_reg && glb_low_reg && pend[3] && !ctrl_b_reg[CB_TMR_PRIO] |-> o_irq_low)
        else $error("timer low missing");
    a_legacy_level: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        !prio_en_reg |-> !o_irq_low) else $error("low request in single level");
    a_gated_request: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        o_irq_high || o_irq_low |-> glb_high_reg && pend != 5'h00) else $error("ungated request");
    a_wake_enabled: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        ext_flag_reg[1] && ext_en_reg[1] |-> o_wake) else $error("no wake");
    a_context_push: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        i_irq_entry |=> o_stack_push && o_shadow == $past(i_context)) else $error("context lost");
    a_shadow_hold: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        !i_irq_entry |=> !o_stack_push && $stable(o_shadow)) else $error("shadow changed");
    c_ext_irq_high: cover property (@(posedge i_core_clk) disable iff (!i_resetn) ext_edge[0] ##2 o_irq_high);
    c_low_level: cover property (@(posedge i_core_clk) disable iff (!i_resetn) o_irq_low);
    c_pin_change: cover property (@(posedge i_core_clk) disable iff (!i_resetn) pch_event ##1 pch_flag_reg);
    c_entry: cover property (@(posedge i_core_clk) disable iff (!i_resetn) o_irq_high ##1 i_irq_entry);
endmodule : irq_sources_reset_cause

// ===== tb/core_pins_model.sv
// Model of the processor core and the pins that feed the interrupt sources.
// Assumes one core clock; every request is changed by non-blocking assignment after a rising edge.
`timescale 1ns/1ps
module core_pins_model
    import irq_rcc_pkg::*;
(
    input wire logic i_core_clk, // Core clock
    output core_event_s o_event, // Core event pulses
    output logic [2:0] o_ext_irq_pin, // External interrupt pins
    output logic [7:0] o_port_a_pin, // Port A pins
    output logic [7:0] o_port_b_pin, // Port B pins
    output logic o_tmr_tick, // Timer increment pulse
    output logic o_tmr_wide, // Timer 16-bit mode
    output logic [15:0] o_tmr_value, // Timer count before tick
    output logic o_irq_entry, // Interrupt entry pulse
    output context_s o_context // Context at entry
);
    initial begin
        o_event = '0;
        o_ext_irq_pin = '0;
        o_port_a_pin = '0;
        o_port_b_pin = '0;
        o_tmr_tick = 1'b0;
        o_tmr_wide = 1'b0;
        o_tmr_value = 16'h0000;
        o_irq_entry = 1'b0;
        o_context = '0;
    end

    task automatic pulse(input core_event_s ev);
        @(posedge i_core_clk) o_event <= ev;
        @(posedge i_core_clk) o_event <= '0;
    endtask : pulse

    task automatic set_ext(input int idx, input logic lvl);
        @(posedge i_core_clk) o_ext_irq_pin[idx] <= lvl;
    endtask : set_ext

    task automatic set_port(input logic [7:0] pa, input logic [7:0] pb);
        @(posedge i_core_clk) o_port_a_pin <= pa;
        o_port_b_pin <= pb;
    endtask : set_port

    // Count is only meaningful beside the tick; it shows garbage otherwise
    task automatic tick(input logic [15:0] v, input logic wide);
        @(posedge i_core_clk) o_tmr_tick <= 1'b1;
        o_tmr_value <= v;
        o_tmr_wide <= wide;
        @(posedge i_core_clk) o_tmr_tick <= 1'b0;
        o_tmr_value <= ~v;
    endtask : tick

    // Context is valid only with the entry pulse
    task automatic enter(input context_s ctx);
        @(posedge i_core_clk) o_irq_entry <= 1'b1;
        o_context <= ctx;
        @(posedge i_core_clk) o_irq_entry <= 1'b0;
        o_context <= ~ctx;
        #1;
    endtask : enter
endmodule : core_pins_model

// ===== tb/irq_sources_reset_cause_tb.sv
// Testbench for the reset-cause and interrupt-source block.
// Assumes the core model drives events, pins, timer and entry; the bench owns the register port.
`timescale 1ns/1ps
`define CHK(nm, got, exp) begin cmp_count++; if ((got) !== (exp)) begin failures++; \
    $display("Error %s expected %h seen %h", nm, exp, got); end end
module irq_sources_reset_cause_tb
    import irq_rcc_pkg::*;
;
    logic i_core_clk = 1'b0;
    logic i_resetn = 1'b0;
    logic [ADDR_W-1:0] i_addr = '0;
    logic [7:0] i_wdata = 8'h00;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic [1:0] i_bor_config = 2'h1;
    logic [7:0] o_rdata, pa, pb;
    core_event_s ev;
    logic [2:0] ext;
    logic tick, wide, entry, o_bor_enable, o_irq_high, o_irq_low, o_wake, o_stack_push;
    logic [15:0] tval;
    logic [20:0] o_push_pc;
    context_s ctx, o_shadow, exp_ctx;
    logic [ADDR_W-1:0] fa;
    logic [7:0] fv;
    int failures = 0;
    int cmp_count = 0;
    int cycles = 0;
    int i, r;

    always #20 i_core_clk = ~i_core_clk;

    irq_sources_reset_cause dut_u (.i_core_clk(i_core_clk), .i_resetn(i_resetn), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_bor_config(i_bor_config),
        .i_event(ev), .i_ext_irq_pin(ext), .i_port_a_pin(pa), .i_port_b_pin(pb), .i_tmr_tick(tick),
        .i_tmr_wide(wide), .i_tmr_value(tval), .i_irq_entry(entry), .i_context(ctx),
        .o_bor_enable(o_bor_enable), .o_irq_high(o_irq_high), .o_irq_low(o_irq_low), .o_wake(o_wake),
        .o_stack_push(o_stack_push), .o_push_pc(o_push_pc), .o_shadow(o_shadow));

    core_pins_model model_u (.i_core_clk(i_core_clk), .o_event(ev), .o_ext_irq_pin(ext), .o_port_a_pin(pa),
        .o_port_b_pin(pb), .o_tmr_tick(tick), .o_tmr_wide(wide), .o_tmr_value(tval), .o_irq_entry(entry),
        .o_context(ctx));

    task automatic close_out();
        $display("Comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : close_out

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
        @(posedge i_core_clk) i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_core_clk) i_wr <= 1'b0;
        #1;
    endtask : wr

    task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [7:0] e, input string nm);
        @(posedge i_core_clk) i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_core_clk) i_rd <= 1'b0;
        #1;
        `CHK(nm, o_rdata, e)
    endtask : rd_chk

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge i_core_clk);
        #1;
    endtask : wait_cyc

    task automatic clr_ext();
        wr(ADDR_IRQ_CTRL_A, 8'h80);
        wr(ADDR_IRQ_CTRL_C, 8'hc0);
    endtask : clr_ext

    // Hang guard: the whole sequence needs well under a thousand cycles
    always @(posedge i_core_clk) begin
        cycles++;
        if (cycles == 2000) begin
            failures++;
            close_out();
        end
    end

    initial begin
        repeat (16) @(posedge i_core_clk);
        i_resetn <= 1'b1;
        rd_chk(ADDR_RESET_CAUSE, 8'h5c, "reset cause at reset");
        rd_chk(ADDR_IRQ_CTRL_A, 8'h00, "ctrl a reset");
        rd_chk(ADDR_IRQ_CTRL_B, CTRL_B_RST, "ctrl b reset");
        rd_chk(ADDR_IRQ_CTRL_C, CTRL_C_RST, "ctrl c reset");
        rd_chk(ADDR_PORT_A_MASK, 8'h00, "mask a reset");
        rd_chk(ADDR_PORT_B_MASK, 8'h00, "mask b reset");
        wr(3'h6, 8'hff);
        rd_chk(3'h6, 8'h00, "unmapped");
        `CHK("bor enable sw", o_bor_enable, 1'b1)
        $display("test registers done");
        model_u.pulse(6'h01);
        rd_chk(ADDR_RESET_CAUSE, 8'h58, "sleep op");
        model_u.pulse(6'h02);
        rd_chk(ADDR_RESET_CAUSE, 8'h5c, "clear op");
        model_u.pulse(6'h10);
        rd_chk(ADDR_RESET_CAUSE, 8'h54, "watchdog expiry");
        model_u.pulse(6'h04);
        rd_chk(ADDR_RESET_CAUSE, 8'h44, "reset op");
        wr(ADDR_RESET_CAUSE, 8'h9f);
        rd_chk(ADDR_RESET_CAUSE, 8'h97, "write flags");
        `CHK("bor enable off", o_bor_enable, 1'b0)
        model_u.pulse(6'h08);
        rd_chk(ADDR_RESET_CAUSE, 8'h96, "brownout");
        wr(ADDR_RESET_CAUSE, 8'h43);
        rd_chk(ADDR_RESET_CAUSE, 8'h47, "sw bor back");
        @(posedge i_core_clk) i_bor_config <= 2'h2;
        rd_chk(ADDR_RESET_CAUSE, 8'h07, "sw bor masked");
        `CHK("bor enable cfg 10", o_bor_enable, 1'b1)
        wr(ADDR_RESET_CAUSE, 8'h03);
        @(posedge i_core_clk) i_bor_config <= 2'h0;
        #1;
        `CHK("bor enable cfg 00", o_bor_enable, 1'b0)
        @(posedge i_core_clk) i_bor_config <= 2'h1;
        rd_chk(ADDR_RESET_CAUSE, 8'h47, "sw bor kept");
        $display("test reset cause done");
        wr(ADDR_IRQ_CTRL_A, 8'h80);
        for (i = 0; i < 3; i++) begin
            for (r = 0; r < 2; r++) begin
                wr(ADDR_IRQ_CTRL_B, (r == 1) ? 8'h75 : 8'h05);
                model_u.set_ext(i, r == 0);
                wait_cyc(4);
                clr_ext();
                model_u.set_ext(i, r == 1);
                wait_cyc(4);
                fa = (i == 0) ? ADDR_IRQ_CTRL_A : ADDR_IRQ_CTRL_C;
                fv = (i == 0) ? 8'h82 : (8'hc0 | (8'h01 << (i - 1)));
                rd_chk(fa, fv, "edge flag");
                `CHK("request masked", o_irq_high, 1'b0)
                wr(fa, fv | ((i == 0) ? 8'h10 : (8'h08 << (i - 1))));
                `CHK("request enabled", o_irq_high, 1'b1)
                wr(ADDR_IRQ_CTRL_A, (i == 0) ? 8'h12 : 8'h00);
                `CHK("wake no global", {o_wake, o_irq_high}, 2'b10)
                clr_ext();
                model_u.set_ext(i, r == 0);
                wait_cyc(4);
                rd_chk(fa, (i == 0) ? 8'h80 : 8'hc0, "opposite edge");
            end
        end
        $display("test external done");
        wr(ADDR_RESET_CAUSE, 8'hc3);
        model_u.set_ext(1, 1'b1);
        wr(ADDR_IRQ_CTRL_C, 8'h88);
        wait_cyc(4);
        `CHK("low needs low global", {o_irq_high, o_irq_low}, 2'b00)
        wr(ADDR_IRQ_CTRL_A, 8'hc0);
        `CHK("low level", {o_irq_high, o_irq_low}, 2'b01)
        wr(ADDR_RESET_CAUSE, 8'h43);
        `CHK("single level", {o_irq_high, o_irq_low}, 2'b10)
        wr(ADDR_RESET_CAUSE, 8'hc3);
        wr(ADDR_IRQ_CTRL_C, 8'hc0);
        model_u.set_ext(0, 1'b1);
        wait_cyc(4);
        wr(ADDR_IRQ_CTRL_A, 8'h92);
        `CHK("ext0 always high", {o_irq_high, o_irq_low}, 2'b10)
        $display("test priority done");
        wr(ADDR_IRQ_CTRL_A, 8'h80);
        model_u.tick(16'h00fe, 1'b0);
        rd_chk(ADDR_IRQ_CTRL_A, 8'h80, "below max");
        model_u.tick(16'h00ff, 1'b1);
        rd_chk(ADDR_IRQ_CTRL_A, 8'h80, "wide low byte max");
        model_u.tick(16'hffff, 1'b1);
        rd_chk(ADDR_IRQ_CTRL_A, 8'h84, "wide overflow");
        wr(ADDR_IRQ_CTRL_A, 8'h80);
        model_u.tick(16'h00ff, 1'b0);
        rd_chk(ADDR_IRQ_CTRL_A, 8'h84, "narrow overflow");
        wr(ADDR_IRQ_CTRL_A, 8'ha4);
        `CHK("timer high", {o_irq_high, o_irq_low}, 2'b10)
        wr(ADDR_IRQ_CTRL_B, 8'h71);
        `CHK("timer low gated", {o_irq_high, o_irq_low}, 2'b00)
        wr(ADDR_IRQ_CTRL_A, 8'he4);
        `CHK("timer low", {o_irq_high, o_irq_low}, 2'b01)
        $display("test timer done");
        wr(ADDR_IRQ_CTRL_A, 8'h80);
        wr(ADDR_PORT_A_MASK, 8'h08);
        model_u.set_port(8'h00, 8'h01);
        wait_cyc(4);
        rd_chk(ADDR_IRQ_CTRL_A, 8'h80, "unmasked change");
        model_u.set_port(8'h08, 8'h01);
        wait_cyc(4);
        rd_chk(ADDR_IRQ_CTRL_A, 8'h81, "port a change");
        wr(ADDR_IRQ_CTRL_A, 8'h80);
        wr(ADDR_PORT_B_MASK, 8'h80);
        model_u.set_port(8'h08, 8'h81);
        wait_cyc(4);
        rd_chk(ADDR_IRQ_CTRL_A, 8'h81, "port b change");
        wr(ADDR_IRQ_CTRL_A, 8'h89);
        `CHK("change request", {o_irq_high, o_irq_low}, 2'b10)
        $display("test pin change done");
        exp_ctx = {21'h1abcde, 8'h5a, 8'hc3, 8'h0f};
        model_u.enter(exp_ctx);
        `CHK("push pulse", o_stack_push, 1'b1)
        `CHK("pushed pc", o_push_pc, exp_ctx.pc)
        `CHK("shadow", o_shadow, exp_ctx)
        wait_cyc(1);
        `CHK("push ends", {o_stack_push, o_shadow}, {1'b0, exp_ctx})
        $display("test entry done");
        close_out();
    end
endmodule : irq_sources_reset_cause_tb
